/* File: design/lrsh_cfg.svh */
`ifndef LRSH_CFG_SVH
`define LRSH_CFG_SVH
`define LRSH_TY_IMM 3'h0
`define LRSH_TY_ISO 3'h1
`define LRSH_TY_PRI 3'h2
`define LRSH_TY_FAIR 3'h3
`define LRSH_TY_RD 3'h4
`define LRSH_TY_WR 3'h5
`define LRSH_TY_ACC 3'h6
`define LRSH_TY_RSV 3'h7
`define LRSH_TYPE_END 5'h04
`define LRSH_SHORT_IDX 5'h06
`define LRSH_LAST_BUS 5'h07
`define LRSH_LAST_RD 5'h08
`define LRSH_LAST_WR 5'h10
`define LRSH_LAST_ACC 5'h05
`define LRSH_SPD_S100 3'h0
`define LRSH_SPD_S200 3'h2
`define LRSH_SPD_S400 3'h4
`define LRSH_CTL_IDLE 2'h0
`define LRSH_CTL_STAT 2'h1
`define LRSH_CTL_RECV 2'h2
`define LRSH_CTL_GRANT 2'h3
`define LRSH_EAA_REG 4'h5
`define LRSH_EAA_BIT 1
`define LRSH_STS_CYC 4'h8
`define LRSH_REG_RST 8'h00
`define LRSH_SW_STAT 8'h40
`define LRSH_ACC_RST 1'b1
`endif

/* File: design/lrsh_pkg.sv */
`default_nettype none
`include "lrsh_cfg.svh"
package lrsh_pkg;
  typedef enum logic [0:0] {SH_IDLE, SH_BITS} lrsh_sh_st_t;
  typedef enum logic [2:0] {
    CS_IDLE, CS_STATUS, CS_GAP, CS_RECV, CS_GRANT, CS_LINK
  } lrsh_ctl_st_t;
  function automatic logic lrsh_spd_ok(input logic [2:0] s);
    return (s == `LRSH_SPD_S100) || (s == `LRSH_SPD_S200) ||
      (s == `LRSH_SPD_S400);
  endfunction
endpackage
`default_nettype wire

/* File: design/lrsh_shifter.sv */
`default_nettype none
`include "lrsh_cfg.svh"
module lrsh_shifter
  import lrsh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic req_in,
  output logic start,
  output logic busy,
  output logic done_ff,
  output logic [2:0] type_ff,
  output logic [3:0] addr_ff,
  output logic [7:0] data_ff,
  output logic [2:0] spd_ff,
  output logic ctl_ff
);
  lrsh_sh_st_t st_ff, nxt_st;
  logic [4:0] cnt_ff;
  logic [2:0] ty_ff;
  logic [11:0] bd_ff;
  logic [12:0] win;
  logic [4:0] last_idx;
  logic short_end, at_last, good;

  assign win = {bd_ff, req_in};
  assign start = (st_ff == SH_IDLE) && req_in;
  assign busy = (st_ff == SH_BITS);
  assign last_idx = (ty_ff == `LRSH_TY_RD) ? `LRSH_LAST_RD :
    (ty_ff == `LRSH_TY_WR) ? `LRSH_LAST_WR :
    (ty_ff[2] || ty_ff == `LRSH_TY_RSV) ? `LRSH_LAST_ACC : `LRSH_LAST_BUS;
  // Bus request may end at bit 6 when that bit is zero
  assign short_end = !ty_ff[2] && cnt_ff == `LRSH_SHORT_IDX && !req_in;
  assign at_last = busy && cnt_ff >= `LRSH_TYPE_END &&
    (cnt_ff == last_idx || short_end);
  // Bad stop bit or reserved type: frame dropped
  assign good = short_end || (!req_in && ty_ff != `LRSH_TY_RSV);

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      SH_IDLE: if (req_in) nxt_st = SH_BITS;
      SH_BITS: if (at_last) nxt_st = SH_IDLE;
      default: nxt_st = SH_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_ff <= SH_IDLE;
      cnt_ff <= 5'h00;
      ty_ff <= 3'h0;
      bd_ff <= 12'h000;
    end
    else
    begin
      st_ff <= nxt_st;
      cnt_ff <= start ? 5'h01 : cnt_ff + 5'h01;
      if (busy && cnt_ff < `LRSH_TYPE_END)
        ty_ff <= {ty_ff[1:0], req_in};
      else
        bd_ff <= win[11:0];
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      done_ff <= 1'b0;
      type_ff <= 3'h0;
      addr_ff <= 4'h0;
      data_ff <= 8'h00;
      spd_ff <= 3'h0;
      ctl_ff <= 1'b0;
    end
    else
    begin
      done_ff <= at_last && good;
      if (at_last)
      begin
        type_ff <= ty_ff;
        addr_ff <= (ty_ff == `LRSH_TY_WR) ? win[12:9] : win[4:1];
        data_ff <= win[8:1];
        spd_ff <= short_end ? win[2:0] : win[3:1];
        ctl_ff <= win[1];
      end
    end
  end
endmodule // lrsh_shifter
`default_nettype wire

/* File: design/lrsh_top.sv */
// What this block does
// - Invalid-speed bus request served, but a null packet is sent.
// - Read request: start, type 100, four address bits, stop; nine bits.
// - Write request: start, type 101, address, eight data bits, stop.
// - Acceleration request: start, type 110, enable bit, stop; six bits.
// - Driving receive on the control pair drops pending fair/priority.
// - Fair/priority request overlapped by receive is ignored.
// - Pending isochronous request clears only on win or bus reset.
// - Immediate request granted as soon as the reception ends.
// - Further bus requests ignored while one is pending.
// - Bus reset clears every pending bus request.
// - Write request updates the register right after its stop bit.
// - Read request answered by status transfer, retried until delivered.
// - Register requests taken any time, even with bus request pending.
// - Further reads ignored while a read is outstanding.
// - Bus reset leaves an outstanding read in place.
// - Acceleration active only while enable bit in register 5 is set.
// - Acceleration request applied immediately, at any time.
// - Bus reset or isochronous request re-enables acceleration.
// - Streams start with one, end with zero, MSB first; line idles low.
// - Type 000 immediate, 001 iso, 010 priority, 011 fair, 111 reserved.
// - Bus request speed in bits 4-6; stop may be omitted if bit 6 zero.
// - Control pair codes: 00 idle, 01 status, 10 receive, 11 grant.
`default_nettype none
`include "lrsh_cfg.svh"
module lrsh_top
  import lrsh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic link_request_line,
  input wire logic [1:0] control_pair_in,
  output logic [1:0] control_pair_out_ff,
  output logic control_pair_oe_n_ff,
  output logic [1:0] d_out_ff,
  output logic d_oe_n_ff,
  input wire logic rx_active,
  input wire logic bus_reset,
  input wire logic arb_won,
  output logic arb_req_ff,
  output logic [1:0] arb_req_kind_ff,
  output logic tx_null_ff,
  output logic [2:0] tx_speed_ff,
  output logic arbitration_accel_enable_ff,
  input wire logic [7:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata_ff
);
  function automatic logic in_regs(input logic [7:0] a);
    return a[7:6] == 2'h0 && a[1:0] == 2'h0;
  endfunction

  logic sh_start, sh_busy, fr_done, fr_ctl;
  logic [2:0] fr_type, fr_spd;
  logic [3:0] fr_addr;
  logic [7:0] fr_data;

  lrsh_shifter u_shifter (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .req_in(link_request_line),
    .start(sh_start),
    .busy(sh_busy),
    .done_ff(fr_done),
    .type_ff(fr_type),
    .addr_ff(fr_addr),
    .data_ff(fr_data),
    .spd_ff(fr_spd),
    .ctl_ff(fr_ctl)
  );

  lrsh_ctl_st_t st_ff, nxt_st;
  logic [7:0] reg_ff [16];
  logic pend_ff, rx_hit_ff, rd_pend_ff, acc_on_ff;
  logic [1:0] pend_type_ff;
  logic [2:0] pend_spd_ff;
  logic [3:0] rd_addr_ff, sts_cnt_ff;
  logic [15:0] sts_sh_ff, sts_word;
  logic bus_fr, fp_fr, take_req, fp_pend, imm_pend, drop_req;
  logic grant_rdy, recv_now, nxt_rx_hit, nxt_acc, eaa;
  logic take_rd, sts_done, lw_hit, sw_reg_wr;
  logic [1:0] nxt_ctl;
  logic [31:0] rd_val;

  // Frame classification
  assign bus_fr = fr_done && !fr_type[2];
  assign fp_fr = bus_fr && fr_type[1];
  assign recv_now = control_pair_out_ff == `LRSH_CTL_RECV;
  // Receive seen anywhere inside the stream spoils a fair/priority frame
  assign nxt_rx_hit = sh_start ? recv_now :
    (rx_hit_ff || (sh_busy && recv_now));
  assign take_req = bus_fr && !pend_ff &&
    !(fp_fr && rx_hit_ff);
  assign fp_pend = pend_ff && pend_type_ff[1];
  assign imm_pend = pend_ff && pend_type_ff == 2'(`LRSH_TY_IMM);
  // Iso stays until won; fair/priority also lost on receive
  assign drop_req = bus_reset || st_ff == CS_GRANT ||
    (st_ff == CS_RECV && fp_pend);
  assign grant_rdy = imm_pend || (pend_ff && arb_won);

  // Register requests are independent of the bus request path
  assign take_rd = fr_done && fr_type == `LRSH_TY_RD &&
    !rd_pend_ff;
  assign lw_hit = fr_done && fr_type == `LRSH_TY_WR;
  assign sw_reg_wr = sw_wr && in_regs(sw_addr);
  assign sts_word = {4'h0, rd_addr_ff, reg_ff[rd_addr_ff]};
  assign sts_done = st_ff == CS_STATUS && nxt_st == CS_GAP;

  // Acceleration enable
  assign eaa = reg_ff[`LRSH_EAA_REG][`LRSH_EAA_BIT];
  assign nxt_acc = (bus_reset || (fr_done && fr_type == `LRSH_TY_ISO)) ?
    1'b1 :
    (fr_done && fr_type == `LRSH_TY_ACC) ? fr_ctl :
    acc_on_ff;

  always_comb
  begin
    nxt_st = st_ff;
    case (st_ff)
      CS_IDLE:
        if (rx_active)
          nxt_st = CS_RECV;
        else if (grant_rdy)
          nxt_st = CS_GRANT;
        else if (rd_pend_ff)
          nxt_st = CS_STATUS;
      CS_STATUS:
        // A packet arriving cuts the transfer; retried after idle
        if (rx_active)
          nxt_st = CS_RECV;
        else if (sts_cnt_ff == `LRSH_STS_CYC)
          nxt_st = CS_GAP;
      CS_GAP:
        nxt_st = rx_active ? CS_RECV : CS_IDLE;
      CS_RECV:
        if (!rx_active)
          nxt_st = imm_pend ? CS_GRANT : CS_IDLE;
      CS_GRANT:
        nxt_st = CS_LINK;
      CS_LINK:
        if (control_pair_in == `LRSH_CTL_IDLE)
          nxt_st = CS_IDLE;
      default:
        nxt_st = CS_IDLE;
    endcase
  end

  assign nxt_ctl = (nxt_st == CS_STATUS) ? `LRSH_CTL_STAT :
    (nxt_st == CS_RECV) ? `LRSH_CTL_RECV :
    (nxt_st == CS_GRANT) ? `LRSH_CTL_GRANT :
    `LRSH_CTL_IDLE;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_ff <= CS_IDLE;
      control_pair_out_ff <= `LRSH_CTL_IDLE;
      control_pair_oe_n_ff <= 1'b0;
      d_oe_n_ff <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
      control_pair_out_ff <= nxt_ctl;
      // Pins released only while the link owns the interface
      control_pair_oe_n_ff <= nxt_st == CS_LINK;
      d_oe_n_ff <= nxt_st == CS_LINK;
    end
  end

  // Status shifter, two bits per cycle, most significant first
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      d_out_ff <= 2'h0;
      sts_sh_ff <= 16'h0000;
      sts_cnt_ff <= 4'h0;
    end
    else if (nxt_st == CS_STATUS && st_ff != CS_STATUS)
    begin
      d_out_ff <= sts_word[15:14];
      sts_sh_ff <= {sts_word[13:0], 2'h0};
      sts_cnt_ff <= 4'h1;
    end
    else if (nxt_st == CS_STATUS)
    begin
      d_out_ff <= sts_sh_ff[15:14];
      sts_sh_ff <= {sts_sh_ff[13:0], 2'h0};
      sts_cnt_ff <= sts_cnt_ff + 4'h1;
    end
    else
      d_out_ff <= 2'h0;
  end

  // Pending bus request
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend_ff <= 1'b0;
      pend_type_ff <= 2'h0;
      pend_spd_ff <= 3'h0;
      rx_hit_ff <= 1'b0;
    end
    else
    begin
      rx_hit_ff <= nxt_rx_hit;
      if (take_req)
      begin
        pend_ff <= 1'b1;
        pend_type_ff <= fr_type[1:0];
        pend_spd_ff <= fr_spd;
      end
      else if (drop_req)
        pend_ff <= 1'b0;
    end
  end

  // Bus request handed to arbitration and transmit paths
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      arb_req_ff <= 1'b0;
      arb_req_kind_ff <= 2'h0;
      tx_null_ff <= 1'b0;
      tx_speed_ff <= 3'h0;
    end
    else
    begin
      arb_req_ff <= pend_ff && !drop_req && !imm_pend;
      arb_req_kind_ff <= pend_type_ff;
      if (nxt_st == CS_GRANT)
      begin
        tx_speed_ff <= pend_spd_ff;
        // Invalid speed: link data is discarded; a null packet goes out instead
        tx_null_ff <= !lrsh_spd_ok(pend_spd_ff);
      end
      else if (nxt_st == CS_IDLE)
        tx_null_ff <= 1'b0;
    end
  end

  // Outstanding register read survives bus reset
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      rd_pend_ff <= 1'b0;
      rd_addr_ff <= 4'h0;
    end
    else if (take_rd)
    begin
      rd_pend_ff <= 1'b1;
      rd_addr_ff <= fr_addr;
    end
    else if (sts_done)
      rd_pend_ff <= 1'b0;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      acc_on_ff <= `LRSH_ACC_RST;
      arbitration_accel_enable_ff <= 1'b0;
    end
    else
    begin
      acc_on_ff <= nxt_acc;
      arbitration_accel_enable_ff <= nxt_acc && eaa;
    end
  end

  // Link write beats a software write to the same register
  generate
    for (genvar gi = 0; gi < 16; gi++)
    begin : g_reg
      always_ff @(posedge ref_clk)
      begin
        if (!rst_n)
          reg_ff[gi] <= `LRSH_REG_RST;
        else if (lw_hit && fr_addr == 4'(gi))
          reg_ff[gi] <= fr_data;
        else if (sw_reg_wr && sw_addr[5:2] == 4'(gi))
          reg_ff[gi] <= sw_wdata[7:0];
      end
    end
  endgenerate

  assign rd_val = in_regs(sw_addr) ? {24'h0, reg_ff[sw_addr[5:2]]} :
    (sw_addr == `LRSH_SW_STAT) ?
    {22'h0, acc_on_ff, arbitration_accel_enable_ff, rd_pend_ff,
    rd_addr_ff, pend_ff, pend_type_ff} : 32'h0;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      sw_rdata_ff <= 32'h0;
    else
      sw_rdata_ff <= sw_rd ? rd_val : 32'h0;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  chk_wr_lands: assert property (
    lw_hit |=> reg_ff[$past(fr_addr)] == $past(fr_data))
    else $error("register write not applied");
  chk_breset_clear: assert property (
    bus_reset && !take_req |=> !pend_ff)
    else $error("bus request survived bus reset");
  chk_rd_keep: assert property (
    rd_pend_ff && bus_reset && st_ff != CS_STATUS |=> rd_pend_ff)
    else $error("bus reset dropped outstanding read");
  chk_recv_drop: assert property (
    st_ff == CS_RECV && fp_pend |=> !pend_ff)
    else $error("fair or priority kept through receive");
  chk_iso_hold: assert property (
    pend_ff && pend_type_ff == 2'(`LRSH_TY_ISO) && !bus_reset &&
    st_ff != CS_GRANT |=> pend_ff && pend_type_ff == 2'(`LRSH_TY_ISO))
    else $error("isochronous request cleared early");
  chk_imm_grant: assert property (
    st_ff == CS_RECV && !rx_active && imm_pend
    |=> control_pair_out_ff == `LRSH_CTL_GRANT ##1
    control_pair_oe_n_ff)
    else $error("no grant after reception");
  chk_req_ignore: assert property (
    pend_ff && bus_fr |=> pend_type_ff == $past(pend_type_ff))
    else $error("second bus request accepted");
  chk_rx_spoil: assert property (
    fp_fr && rx_hit_ff && !pend_ff |=> !pend_ff)
    else $error("request overlapped by receive kept");
  chk_rd_ignore: assert property (
    rd_pend_ff && fr_done && fr_type == `LRSH_TY_RD
    |=> rd_addr_ff == $past(rd_addr_ff))
    else $error("second read accepted");
  chk_eaa_gate: assert property (
    !eaa [*2] |-> !arbitration_accel_enable_ff)
    else $error("acceleration on with enable bit clear");
  chk_accel_reen: assert property (
    bus_reset && eaa |=> arbitration_accel_enable_ff)
    else $error("acceleration not re-enabled");
  chk_null_tx: assert property (
    control_pair_out_ff == `LRSH_CTL_GRANT && !lrsh_spd_ok(tx_speed_ff)
    |-> tx_null_ff)
    else $error("invalid speed grant without null packet");
  chk_status_start: assert property (
    st_ff == CS_IDLE && rd_pend_ff && !rx_active && !grant_rdy
    |=> control_pair_out_ff == `LRSH_CTL_STAT && sts_cnt_ff == 4'h1)
    else $error("status transfer did not start");
  // A receive may cut the transfer at any pair, so each step is checked
  chk_status_len: assert property (
    control_pair_out_ff == `LRSH_CTL_STAT && !rx_active &&
    sts_cnt_ff != `LRSH_STS_CYC |=> control_pair_out_ff == `LRSH_CTL_STAT)
    else $error("status transfer cut short");
  chk_status_end: assert property (
    control_pair_out_ff == `LRSH_CTL_STAT && !rx_active &&
    sts_cnt_ff == `LRSH_STS_CYC
    |=> control_pair_out_ff == `LRSH_CTL_IDLE && !rd_pend_ff)
    else $error("status transfer not ended after eight pairs");
endmodule // lrsh_top
`default_nettype wire

/* File: dv/lrsh_link_model.sv */
`default_nettype none
`include "lrsh_cfg.svh"
module lrsh_link_model
  import lrsh_pkg::*;
(
  input wire logic ref_clk,
  input wire logic ctl_oe_n,
  output logic link_request_line,
  output logic [1:0] link_ctl
);
  timeunit 1ns;
  timeprecision 1ps;
  logic held_ff;
  // Shows hold while not owning, so a stale idle never reads as a release;
  // once owning, holds and then idles: the grant is never reused
  always_ff @(posedge ref_clk)
  begin
    held_ff <= ctl_oe_n;
    link_ctl <= (ctl_oe_n && held_ff) ? 2'h0 : 2'h1;
  end
  initial link_request_line = 1'b0;
  // MSB first, one bit per edge; the line falls back low after the stop
  task automatic shift(input logic [16:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
    begin
      @(posedge ref_clk);
      link_request_line <= v[i];
    end
    @(posedge ref_clk);
  endtask
  task automatic reg_rd(input logic [3:0] a);
    shift({8'h00, 1'b1, `LRSH_TY_RD, a, 1'b0}, 9);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    shift({1'b1, `LRSH_TY_WR, a, d, 1'b0}, 17);
  endtask
  task automatic accel(input logic en);
    shift({11'h000, 1'b1, `LRSH_TY_ACC, en, 1'b0}, 6);
  endtask
  // Short form whenever bit 6 is zero, to exercise both lengths
  task automatic bus_req(input logic [2:0] t, input logic [2:0] s);
    if (s[0])
      shift({9'h000, 1'b1, t, s, 1'b0}, 8);
    else
      shift({10'h000, 1'b1, t, s}, 7);
  endtask
endmodule // lrsh_link_model
`default_nettype wire

/* File: dv/link_request_stream_handler_tb.sv */
`default_nettype none
`include "lrsh_cfg.svh"
`define CHK(a, e) \
  begin \
    comparisons++; \
    if ((a) !== (e)) \
    begin \
      errors++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module link_request_stream_handler_tb
  import lrsh_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, rst_n, lrl, rx_active, bus_reset, arb_won, sw_wr, sw_rd;
  logic oe_n, d_oe_n, arb_req, tx_null, accel;
  logic [1:0] ctl_out, link_ctl, d_out, kind;
  logic [2:0] spd;
  logic [7:0] sw_addr;
  logic [31:0] sw_wdata, rdata;
  wire logic [1:0] ctl_in;
  int errors, comparisons, cycles;
  // Wire level: whoever has the enable drives the pair
  assign ctl_in = oe_n ? link_ctl : ctl_out;
  lrsh_top dut(.ref_clk(ref_clk), .rst_n(rst_n), .link_request_line(lrl),
    .control_pair_in(ctl_in), .control_pair_out_ff(ctl_out),
    .control_pair_oe_n_ff(oe_n), .d_out_ff(d_out), .d_oe_n_ff(d_oe_n),
    .rx_active(rx_active), .bus_reset(bus_reset), .arb_won(arb_won),
    .arb_req_ff(arb_req), .arb_req_kind_ff(kind), .tx_null_ff(tx_null),
    .tx_speed_ff(spd), .arbitration_accel_enable_ff(accel),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata_ff(rdata));
  lrsh_link_model link(.ref_clk(ref_clk), .ctl_oe_n(oe_n),
    .link_request_line(lrl), .link_ctl(link_ctl));
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    $display("checks %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic pulse_br;
    @(posedge ref_clk);
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
  endtask
  task automatic pulse_aw;
    @(posedge ref_clk);
    arb_won <= 1'b1;
    @(posedge ref_clk);
    arb_won <= 1'b0;
  endtask
  task automatic rx(input int n);
    @(posedge ref_clk);
    rx_active <= 1'b1;
    repeat (n) @(posedge ref_clk);
    rx_active <= 1'b0;
  endtask
  // One strobe cycle; read data stand only in the cycle after, so look there
  task automatic sw_op(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= wr;
    sw_rd <= !wr;
    @(posedge ref_clk);
    sw_wr <= 1'b0;
    sw_rd <= 1'b0;
    #1;
    if (!wr)
      `CHK(rdata, d);
  endtask
  task automatic wait_ctl(input logic [1:0] c);
    int k;
    k = 0;
    // Callers may arrive on an edge; let its updates settle first
    #1;
    while (ctl_out !== c && k < 60)
    begin
      tick(1);
      k++;
    end
    `CHK(ctl_out, c);
  endtask
  task automatic wait_idle;
    int k;
    k = 0;
    #1;
    while (!(oe_n === 1'b0 && ctl_out === `LRSH_CTL_IDLE) && k < 60)
    begin
      tick(1);
      k++;
    end
    `CHK({oe_n, d_oe_n, ctl_out}, 4'h0);
  endtask
  task automatic get_status(output logic [15:0] w);
    w = 16'h0000;
    for (int i = 0; i < 8; i++)
    begin
      w = {w[13:0], d_out};
      tick(1);
    end
  endtask
  task automatic t_regs;
    link.reg_wr(4'h3, 8'ha5);
    tick(2);
    sw_op(1'b0, 8'h0c, 32'h000000a5);
    sw_op(1'b1, 8'h08, 32'h0000005a);
    sw_op(1'b0, 8'h08, 32'h0000005a);
    sw_op(1'b0, 8'h80, 32'h00000000);
  endtask
  task automatic t_status;
    logic [15:0] w;
    @(posedge ref_clk);
    rx_active <= 1'b1;
    link.reg_rd(4'h3);
    link.reg_rd(4'h4);
    pulse_br();
    @(posedge ref_clk);
    rx_active <= 1'b0;
    wait_ctl(`LRSH_CTL_STAT);
    tick(2);
    @(posedge ref_clk);
    rx_active <= 1'b1;
    tick(2);
    `CHK(ctl_out, `LRSH_CTL_RECV);
    @(posedge ref_clk);
    rx_active <= 1'b0;
    wait_ctl(`LRSH_CTL_STAT);
    get_status(w);
    `CHK(w, 16'h03a5);
    tick(2);
    link.reg_rd(4'h2);
    wait_ctl(`LRSH_CTL_STAT);
    get_status(w);
    `CHK(w, 16'h025a);
  endtask
  task automatic t_grants;
    logic [2:0] ty[3] = '{`LRSH_TY_PRI, `LRSH_TY_ISO,
      `LRSH_TY_FAIR};
    logic [2:0] sp[3] = '{`LRSH_SPD_S100, `LRSH_SPD_S400, 3'h3};
    @(posedge ref_clk);
    rx_active <= 1'b1;
    link.bus_req(`LRSH_TY_IMM, `LRSH_SPD_S200);
    @(posedge ref_clk);
    rx_active <= 1'b0;
    wait_ctl(`LRSH_CTL_GRANT);
    `CHK(spd, `LRSH_SPD_S200);
    tick(1);
    `CHK({oe_n, d_oe_n}, 2'h3);
    wait_idle();
    for (int i = 0; i < 3; i++)
    begin
      tick(1);
      link.bus_req(ty[i], sp[i]);
      tick(2);
      `CHK({arb_req, kind}, {1'b1, ty[i][1:0]});
      pulse_aw();
      wait_ctl(`LRSH_CTL_GRANT);
      `CHK(tx_null, sp[i] == 3'h3);
      `CHK(spd, sp[i]);
      tick(1);
      `CHK({oe_n, d_oe_n, arb_req}, 3'h6);
      wait_idle();
    end
  endtask
  task automatic t_pending;
    link.bus_req(`LRSH_TY_ISO, `LRSH_SPD_S100);
    link.bus_req(`LRSH_TY_FAIR, `LRSH_SPD_S100);
    tick(2);
    `CHK({arb_req, kind}, 3'h5);
    sw_op(1'b0, 8'h40, 32'h00000215);
    link.reg_wr(4'h4, 8'h3c);
    tick(2);
    sw_op(1'b0, 8'h10, 32'h0000003c);
    rx(3);
    tick(2);
    `CHK(arb_req, 1'b1);
    pulse_br();
    tick(2);
    `CHK(arb_req, 1'b0);
    link.bus_req(`LRSH_TY_FAIR, `LRSH_SPD_S100);
    tick(2);
    `CHK(arb_req, 1'b1);
    rx(2);
    tick(2);
    `CHK(arb_req, 1'b0);
    tick(1);
    fork
      link.bus_req(`LRSH_TY_PRI, `LRSH_SPD_S100);
      rx(1);
    join
    tick(2);
    `CHK(arb_req, 1'b0);
    link.bus_req(`LRSH_TY_RSV, `LRSH_SPD_S100);
    tick(2);
    `CHK(arb_req, 1'b0);
  endtask
  task automatic t_accel;
    link.reg_wr(`LRSH_EAA_REG, 8'h02);
    tick(2);
    `CHK(accel, 1'b1);
    link.accel(1'b0);
    tick(2);
    `CHK(accel, 1'b0);
    link.accel(1'b1);
    tick(2);
    `CHK(accel, 1'b1);
    link.accel(1'b0);
    tick(2);
    pulse_br();
    tick(2);
    `CHK(accel, 1'b1);
    link.accel(1'b0);
    tick(2);
    link.bus_req(`LRSH_TY_ISO, `LRSH_SPD_S100);
    tick(2);
    `CHK(accel, 1'b1);
    pulse_br();
    link.reg_wr(`LRSH_EAA_REG, 8'h00);
    tick(2);
    `CHK(accel, 1'b0);
  endtask
  initial
  begin
    {rst_n, rx_active, bus_reset, arb_won, sw_wr, sw_rd} = 6'h00;
    sw_addr = 8'h00;
    sw_wdata = 32'h00000000;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    tick(20);
    rst_n <= 1'b1;
    tick(1);
    `CHK({oe_n, ctl_out, arb_req, accel}, 5'h00);
    t_regs();
    t_status();
    t_grants();
    t_pending();
    t_accel();
    end_sim();
  end
endmodule // link_request_stream_handler_tb
`default_nettype wire
